// ---- tb/test_timer_irq_enable_flags.sv ----
`timescale 1ns/10ps
module test_timer_irq_enable_flags;
  reg I_CLK = 1'b0;
  reg I_RST = 1'b1;
  reg psel = 1'b0, pen = 1'b0, pwr = 1'b0, e_seen;
  reg [11:0] padr = 12'h000;
  reg [31:0] pwd = 32'h0000_0000, rd;
  reg [15:0] cnt = 16'h0100, cmpa = 16'h8000, cmpb = 16'h8000;
  reg [3:0] edg = 4'h0;
  wire rdy, err, irq, clr;
  wire [31:0] prd;
  wire [6:0] req, taken;
  integer n_mismatch = 0, total_checks = 0, cyc = 0, k;
  tie_main u_dut (.I_CLK(I_CLK), .I_RST(I_RST), .i_PSEL(psel),
    .i_PENABLE(pen), .i_PWRITE(pwr), .i_PADDR(padr), .i_PWDATA(pwd),
    .i_COUNTER(cnt), .i_COMPARE_A(cmpa), .i_COMPARE_B(cmpb),
    .i_CAPTURE_EDGE(edg), .o_PREADY(rdy), .o_PSLVERR(err), .o_PRDATA(prd),
    .o_CAPTURE_A_IRQ(req[6]), .o_CAPTURE_B_IRQ(req[5]),
    .o_CAPTURE_C_IRQ(req[4]), .o_CAPTURE_D_IRQ(req[3]),
    .o_COMPARE_A_IRQ(req[2]), .o_COMPARE_B_IRQ(req[1]),
    .o_COUNTER_OVERFLOW_IRQ(req[0]), .o_IRQ(irq),
    .o_CLEAR_ON_COMPARE_A(clr));
  tie_irq_host u_host (.I_CLK(I_CLK), .I_RST(I_RST), .i_req(req),
    .o_taken(taken));
  initial forever #20 I_CLK = ~I_CLK;
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  always @(posedge I_CLK) begin
    cyc = cyc + 1;
    // the whole run needs about 490 cycles
    if (cyc == 6000) begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  task chk(input [31:0] s, input [31:0] e, input string nm);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge I_CLK);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge I_CLK);
      pen <= 1'b1;
      @(posedge I_CLK);
      while (rdy !== 1'b1) @(posedge I_CLK);
      rd = prd;
      e_seen = err;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e, input string nm);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e, nm);
    end
  endtask
  // one source event: 0..3 capture A..D, 4..5 compare A..B, 6 wrap
  task ev(input integer i);
    begin
      @(posedge I_CLK);
      if (i < 4) edg <= 4'h1 << i;
      else if (i == 4) cmpa <= cnt;
      else if (i == 5) cmpb <= cnt;
      else cnt <= 16'hFFFF;
      @(posedge I_CLK);
      edg <= 4'h0;
      cmpa <= 16'h8000;
      cmpb <= 16'h8000;
      if (i == 6) cnt <= 16'h0000;
      @(posedge I_CLK);
      cnt <= 16'h0100;
      repeat (3) @(posedge I_CLK);
    end
  endtask
  initial begin
    repeat (6) @(posedge I_CLK);
    I_RST <= 1'b0;
    rdc(12'h000, 32'h0000_0001, "enables reset");
    rdc(12'h004, 32'h0000_0000, "status reset");
    apb(1'b1, 12'h000, 32'h0000_00FE);
    rdc(12'h000, 32'h0000_00FF, "enables all");
    apb(1'b1, 12'h000, 32'h0000_0000);
    rdc(12'h000, 32'h0000_0001, "enables none");
    $display("register test done");
    for (k = 0; k < 7; k = k + 1) begin
      ev(k);
      chk(req, 7'h00, "req masked");
      rdc(12'h004, 32'h80 >> k, "flag set");
      apb(1'b1, 12'h000, 32'h80 >> k);
      repeat (3) @(posedge I_CLK);
      chk(req, 7'h40 >> k, "req on");
      chk(irq, 1'b1, "irq on");
      apb(1'b1, 12'h004, 32'h0000_00FE);
      apb(1'b1, 12'h004, 32'h0000_0000);
      rdc(12'h004, 32'h80 >> k, "flag kept");
      apb(1'b1, 12'h004, 32'h0000_0000);
      repeat (3) @(posedge I_CLK);
      chk(req, 7'h00, "req cleared");
      chk(irq, 1'b0, "irq cleared");
      ev(k);
      chk(req, 7'h40 >> k, "req again");
      rdc(12'h004, 32'h80 >> k, "flag again");
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0000);
    end
    chk(taken, 7'h7F, "requests seen");
    $display("event test done");
    @(posedge I_CLK);
    cnt <= 16'h0345;
    ev(0);
    apb(1'b1, 12'h008, 32'h0000_0001);
    @(posedge I_CLK);
    cnt <= 16'h0234;
    ev(0);
    rdc(12'h00C, 32'h0000_0234, "capture a");
    rdc(12'h014, 32'h0000_0345, "capture c");
    rdc(12'h004, 32'h0000_0080, "flag a buffered");
    rdc(12'h01C, 32'h0000_0000, "unmapped data");
    chk(e_seen, 1'b1, "unmapped error");
    // buffer b pushes old b into d; a c edge in buffer a mode keeps c
    apb(1'b1, 12'h008, 32'h0000_0003);
    @(posedge I_CLK);
    cnt <= 16'h0456;
    ev(1);
    @(posedge I_CLK);
    cnt <= 16'h0567;
    ev(1);
    ev(2);
    rdc(12'h010, 32'h0000_0567, "capture b");
    rdc(12'h018, 32'h0000_0456, "capture d buffered");
    rdc(12'h014, 32'h0000_0345, "capture c kept");
    // flag a was armed by the last status read, b and c were not
    apb(1'b1, 12'h004, 32'h0000_0001);
    repeat (2) @(posedge I_CLK);
    rdc(12'h004, 32'h0000_0061, "status after clear");
    chk(clr, 1'b1, "clear on compare a");
    $display("buffer test done");
    close_out;
  end
endmodule // test_timer_irq_enable_flags

// ---- tb/tie_irq_host.sv ----
`timescale 1ns/10ps
// interrupt controller side: remembers every request line that went high
module tie_irq_host (
  input wire I_CLK,
  input wire I_RST,
  input wire [6:0] i_req,
  output reg [6:0] o_taken
);
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST)
      o_taken <= 7'h00;
    else
      o_taken <= o_taken | i_req;
  end
endmodule // tie_irq_host

// ---- tb/tie_main_asserts.sv ----
`timescale 1ns/10ps
module tie_main_chk #(
  parameter CNT_WIDTH = 16
) (
  input wire I_CLK,
  input wire I_RST,
  input wire i_PSEL,
  input wire i_PENABLE,
  input wire i_PWRITE,
  input wire [11:0] i_PADDR,
  input wire [31:0] i_PWDATA,
  input wire [CNT_WIDTH-1:0] i_COUNTER,
  input wire [3:0] i_CAPTURE_EDGE,
  input wire o_PREADY,
  input wire o_PSLVERR,
  input wire [31:0] o_PRDATA,
  input wire o_CAPTURE_A_IRQ,
  input wire o_COUNTER_OVERFLOW_IRQ
);
  // shadow of the enables, taken from completed writes only
  reg [7:0] en_q;
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST)
      en_q <= 8'h00;
    else if (i_PSEL && i_PENABLE && o_PREADY && i_PWRITE && i_PADDR == 12'h000)
      en_q <= i_PWDATA[7:0];
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence seq_wrap;
    i_COUNTER == 16'hFFFF ##1 i_COUNTER == 16'h0000;
  endsequence
  AST_WAIT_STATE: assert property (i_PSEL && i_PENABLE && !o_PREADY
    |=> o_PREADY) else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (o_PREADY |=> !o_PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (o_PSLVERR |-> o_PREADY)
    else $error("error without ready");
  AST_UNMAPPED: assert property (o_PREADY && !i_PWRITE && i_PADDR > 12'h018
    |-> o_PSLVERR && o_PRDATA == 32'h0000_0000) else $error("unmapped read");
  AST_ENABLE_READ: assert property (
    o_PREADY && !i_PWRITE && i_PADDR == 12'h000
    |-> o_PRDATA == {24'h00_0000, en_q[7:1], 1'b1}) else $error("enables read");
  AST_CAP_A_ON: assert property (
    i_CAPTURE_EDGE[0] && en_q[7] ##1 en_q[7] |-> ##[0:1] o_CAPTURE_A_IRQ)
    else $error("capture a request missing");
  AST_CAP_A_OFF: assert property ((!en_q[7]) [*3] |-> !o_CAPTURE_A_IRQ)
    else $error("capture a request while disabled");
  AST_OVF_ON: assert property (
    seq_wrap ##0 en_q[1] |-> ##[1:2] o_COUNTER_OVERFLOW_IRQ)
    else $error("overflow request missing");
endmodule // tie_main_chk
bind tie_main tie_main_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (.*);

// ---- verilog/tie_capture.v ----
`timescale 1ns/10ps
module tie_capture #(
  parameter WIDTH = 16
) (
  input wire i_clk,
  input wire i_rst,
  input wire [3:0] i_edge,
  input wire i_buf_a,
  input wire i_buf_b,
  input wire [WIDTH-1:0] i_count,
  output reg [WIDTH-1:0] o_cap_a,
  output reg [WIDTH-1:0] o_cap_b,
  output reg [WIDTH-1:0] o_cap_c,
  output reg [WIDTH-1:0] o_cap_d
);
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cap_a <= {WIDTH{1'b0}};
      o_cap_b <= {WIDTH{1'b0}};
      o_cap_c <= {WIDTH{1'b0}};
      o_cap_d <= {WIDTH{1'b0}};
    end else begin
      if (i_edge[0]) begin
        o_cap_a <= i_count;
      end
      if (i_edge[1]) begin
        o_cap_b <= i_count;
      end
      // in buffer mode c and d only hold the pushed old value
      if (i_buf_a) begin
        if (i_edge[0]) begin
          o_cap_c <= o_cap_a;
        end
      end else if (i_edge[2]) begin
        o_cap_c <= i_count;
      end
      if (i_buf_b) begin
        if (i_edge[1]) begin
          o_cap_d <= o_cap_b;
        end
      end else if (i_edge[3]) begin
        o_cap_d <= i_count;
      end
    end
  end
endmodule // tie_capture

// ---- verilog/tie_defs.vh ----
`ifndef TIE_DEFS_VH
`define TIE_DEFS_VH

// register byte offsets
`define TIE_OFF_ENABLES 12'h000
`define TIE_OFF_STATUS 12'h004
`define TIE_OFF_BUFFER 12'h008
`define TIE_OFF_CAP_A 12'h00C
`define TIE_OFF_CAP_B 12'h010
`define TIE_OFF_CAP_C 12'h014
`define TIE_OFF_CAP_D 12'h018

// bit positions shared by enables and control/status
`define TIE_BIT_CAP_A 7
`define TIE_BIT_CAP_B 6
`define TIE_BIT_CAP_C 5
`define TIE_BIT_CAP_D 4
`define TIE_BIT_CMP_A 3
`define TIE_BIT_CMP_B 2
`define TIE_BIT_OVF 1
`define TIE_BIT_LOW 0
`define TIE_NUM_SRC 7

// buffer configuration bits
`define TIE_BIT_BUF_A 0
`define TIE_BIT_BUF_B 1

// reset values and fixed patterns
`define TIE_EN_RESET 7'h00
`define TIE_CNT_MAX 16'hFFFF
`define TIE_CNT_ZERO 16'h0000
`define TIE_DATA_ZERO 32'h0000_0000

`endif

// ---- verilog/tie_flag.v ----
`timescale 1ns/10ps
module tie_flag (
  input wire i_clk,
  input wire i_rst,
  input wire i_set,
  input wire i_seen,
  input wire i_wr,
  input wire i_wbit,
  output reg o_flag
);
  reg armed_q;

  // arming needs a read that returned a one
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (i_wr) begin
      armed_q <= 1'b0;
    end else if (i_seen && o_flag) begin
      armed_q <= 1'b1;
    end
  end

  // set wins over a clear in the same cycle
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_wr && !i_wbit && armed_q) begin
      o_flag <= 1'b0;
    end
  end
endmodule // tie_flag

// ---- verilog/tie_main.v ----
`timescale 1ns/10ps
`include "tie_defs.vh"
module tie_main #(
  parameter CNT_WIDTH = 16
) (
  input wire I_CLK,
  input wire I_RST,
  input wire i_PSEL,
  input wire i_PENABLE,
  input wire i_PWRITE,
  input wire [11:0] i_PADDR,
  input wire [31:0] i_PWDATA,
  input wire [CNT_WIDTH-1:0] i_COUNTER,
  input wire [CNT_WIDTH-1:0] i_COMPARE_A,
  input wire [CNT_WIDTH-1:0] i_COMPARE_B,
  input wire [3:0] i_CAPTURE_EDGE,
  output reg o_PREADY,
  output reg o_PSLVERR,
  output reg [31:0] o_PRDATA,
  output reg o_CAPTURE_A_IRQ,
  output reg o_CAPTURE_B_IRQ,
  output reg o_CAPTURE_C_IRQ,
  output reg o_CAPTURE_D_IRQ,
  output reg o_COMPARE_A_IRQ,
  output reg o_COMPARE_B_IRQ,
  output reg o_COUNTER_OVERFLOW_IRQ,
  output reg o_IRQ,
  output reg o_CLEAR_ON_COMPARE_A
);
  reg [7:1] enables_q;
  reg clear_sel_q;
  reg [1:0] buffer_q;
  reg [CNT_WIDTH-1:0] count_prev_q;
  reg [31:0] rdata_d;
  reg rd_err_d;
  wire [7:1] flags;
  wire [7:1] flag_set;
  wire [7:0] control_status;
  wire [7:0] enables_view;
  wire [CNT_WIDTH-1:0] cap_a;
  wire [CNT_WIDTH-1:0] cap_b;
  wire [CNT_WIDTH-1:0] cap_c;
  wire [CNT_WIDTH-1:0] cap_d;
  wire access;
  wire wr_done;
  wire rd_seen;
  wire wr_status;
  wire [7:1] requests;

  // one wait state lets read data come from a flip-flop
  assign access = i_PSEL && i_PENABLE;
  assign wr_done = access && o_PREADY && i_PWRITE;
  assign rd_seen = access && !o_PREADY && !i_PWRITE &&
                   (i_PADDR == `TIE_OFF_STATUS);
  assign wr_status = wr_done && (i_PADDR == `TIE_OFF_STATUS);

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_PREADY <= 1'b0;
    end else begin
      o_PREADY <= access && !o_PREADY;
    end
  end

  // register writes
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      enables_q <= `TIE_EN_RESET;
      clear_sel_q <= 1'b0;
      buffer_q <= 2'b00;
    end else if (wr_done) begin
      if (i_PADDR == `TIE_OFF_ENABLES) begin
        enables_q <= i_PWDATA[7:1];
      end else if (i_PADDR == `TIE_OFF_STATUS) begin
        clear_sel_q <= i_PWDATA[`TIE_BIT_LOW];
      end else if (i_PADDR == `TIE_OFF_BUFFER) begin
        buffer_q <= i_PWDATA[1:0];
      end
    end
  end

  // event detection
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      count_prev_q <= {CNT_WIDTH{1'b0}};
    end else begin
      count_prev_q <= i_COUNTER;
    end
  end

  assign flag_set[`TIE_BIT_CAP_A] = i_CAPTURE_EDGE[0];
  assign flag_set[`TIE_BIT_CAP_B] = i_CAPTURE_EDGE[1];
  assign flag_set[`TIE_BIT_CAP_C] = i_CAPTURE_EDGE[2];
  assign flag_set[`TIE_BIT_CAP_D] = i_CAPTURE_EDGE[3];
  // equality is a level: the flag re-sets while the match lasts
  assign flag_set[`TIE_BIT_CMP_A] = (i_COUNTER == i_COMPARE_A);
  assign flag_set[`TIE_BIT_CMP_B] = (i_COUNTER == i_COMPARE_B);
  assign flag_set[`TIE_BIT_OVF] = (count_prev_q == `TIE_CNT_MAX) &&
                                  (i_COUNTER == `TIE_CNT_ZERO);

  genvar g;
  generate
    for (g = 1; g <= `TIE_NUM_SRC; g = g + 1) begin : g_flag
      tie_flag u_flag (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_set(flag_set[g]),
        .i_seen(rd_seen),
        .i_wr(wr_status),
        .i_wbit(i_PWDATA[g]),
        .o_flag(flags[g])
      );
    end
  endgenerate

  tie_capture #(
    .WIDTH(CNT_WIDTH)
  ) u_capture (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_edge(i_CAPTURE_EDGE),
    .i_buf_a(buffer_q[`TIE_BIT_BUF_A]),
    .i_buf_b(buffer_q[`TIE_BIT_BUF_B]),
    .i_count(i_COUNTER),
    .o_cap_a(cap_a),
    .o_cap_b(cap_b),
    .o_cap_c(cap_c),
    .o_cap_d(cap_d)
  );

  assign control_status = {flags, clear_sel_q};
  assign enables_view = {enables_q, 1'b1};

  // read mux
  always @* begin
    rdata_d = `TIE_DATA_ZERO;
    rd_err_d = 1'b0;
    if (i_PADDR == `TIE_OFF_ENABLES) begin
      rdata_d[7:0] = enables_view;
    end else if (i_PADDR == `TIE_OFF_STATUS) begin
      rdata_d[7:0] = control_status;
    end else if (i_PADDR == `TIE_OFF_BUFFER) begin
      rdata_d[1:0] = buffer_q;
    end else if (i_PADDR == `TIE_OFF_CAP_A) begin
      rdata_d[CNT_WIDTH-1:0] = cap_a;
    end else if (i_PADDR == `TIE_OFF_CAP_B) begin
      rdata_d[CNT_WIDTH-1:0] = cap_b;
    end else if (i_PADDR == `TIE_OFF_CAP_C) begin
      rdata_d[CNT_WIDTH-1:0] = cap_c;
    end else if (i_PADDR == `TIE_OFF_CAP_D) begin
      rdata_d[CNT_WIDTH-1:0] = cap_d;
    end else begin
      rd_err_d = 1'b1;
    end
  end

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_PRDATA <= `TIE_DATA_ZERO;
      o_PSLVERR <= 1'b0;
    end else if (access && !o_PREADY) begin
      o_PRDATA <= i_PWRITE ? `TIE_DATA_ZERO : rdata_d;
      o_PSLVERR <= rd_err_d;
    end else begin
      o_PSLVERR <= 1'b0;
    end
  end

  // interrupt requests, registered: one cycle after flag or enable
  assign requests = flags & enables_q;
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_CAPTURE_A_IRQ <= 1'b0;
      o_CAPTURE_B_IRQ <= 1'b0;
      o_CAPTURE_C_IRQ <= 1'b0;
      o_CAPTURE_D_IRQ <= 1'b0;
      o_COMPARE_A_IRQ <= 1'b0;
      o_COMPARE_B_IRQ <= 1'b0;
      o_COUNTER_OVERFLOW_IRQ <= 1'b0;
      o_IRQ <= 1'b0;
      o_CLEAR_ON_COMPARE_A <= 1'b0;
    end else begin
      o_CAPTURE_A_IRQ <= requests[`TIE_BIT_CAP_A];
      o_CAPTURE_B_IRQ <= requests[`TIE_BIT_CAP_B];
      o_CAPTURE_C_IRQ <= requests[`TIE_BIT_CAP_C];
      o_CAPTURE_D_IRQ <= requests[`TIE_BIT_CAP_D];
      o_COMPARE_A_IRQ <= requests[`TIE_BIT_CMP_A];
      o_COMPARE_B_IRQ <= requests[`TIE_BIT_CMP_B];
      o_COUNTER_OVERFLOW_IRQ <= requests[`TIE_BIT_OVF];
      o_IRQ <= |requests;
      o_CLEAR_ON_COMPARE_A <= clear_sel_q;
    end
  end
endmodule // tie_main
